// *** inc/cdp_pkg.sv ***
// charger detection and port power status: shared constants and types
package cdp_pkg;

    // ==========================================================
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_UCD      = 8'hE2;  // upstream_charger_detection
    localparam logic [7:0]  IDX_PPS      = 8'hE5;  // port_power_status
    localparam logic [7:0]  IDX_IRQ_STS  = 8'hF0;  // interrupt status, write one to clear
    localparam logic [7:0]  IDX_IRQ_MASK = 8'hF1;  // interrupt mask

    // ==========================================================
    // field positions and reset values
    localparam int          UCD_CLS_LSB  = 5;       // class code 7:5
    localparam int          UCD_DONE_BIT = 4;       // detection_done_flag
    localparam int          UCD_FND_BIT  = 1;       // charger_found_low
    localparam int          UCD_TRG_BIT  = 0;       // manual_detect_trigger
    localparam int          PPS_LSB      = 1;       // port status 3:1
    localparam logic [7:0]  UCD_RST      = 8'h02;
    localparam logic [7:0]  PPS_RST      = 8'h00;
    localparam int          NPORT        = 3;

    // ==========================================================
    // class codes
    localparam logic [2:0]  CLS_INCOMPLETE = 3'h0;
    localparam logic [2:0]  CLS_DCP        = 3'h1;
    localparam logic [2:0]  CLS_CDP        = 3'h2;
    localparam logic [2:0]  CLS_SDP        = 3'h3;
    localparam logic [2:0]  CLS_DISABLED   = 3'h7;

    // ==========================================================
    // interrupt bits
    localparam int          IRQ_W     = 3;
    localparam int          IRQ_DONE  = 0;          // detection finished
    localparam int          IRQ_FOUND = 1;          // unmasked charger found
    localparam int          IRQ_PWR   = 2;          // port power status changed

    // raw result from the analog detector; mask bit index equals the code
    typedef enum logic [1:0] {
        KIND_DCP  = 2'h0,
        KIND_CDP  = 2'h1,
        KIND_SDP  = 2'h2,
        KIND_NONE = 2'h3
    } cdp_kind_t;

    // detection sequencer states
    typedef enum logic [0:0] {
        SEQ_IDLE   = 1'h0,
        SEQ_MANUAL = 1'h1
    } cdp_seq_state_t;

endpackage

// *** inc/cdp_ctl_if.sv ***
// control and status signals between the register bank and its helpers
`timescale 1ns/1ps
interface cdp_ctl_if;
    import cdp_pkg::*;
    logic           wr_trigger;    // software wrote one to the trigger bit
    logic           wr_found_high; // software wrote one to the found bit
    logic           ext_sel;       // extended_detection_select
    logic           det_disable;   // detection disabled
    logic           det_done;      // detector finished a sequence
    cdp_kind_t      det_kind;      // detector result
    logic [2:0]     type_mask;     // charger_type_mask
    logic           trigger;       // manual_detect_trigger
    logic           done_flag;     // detection_done_flag
    logic           found_low;     // charger_found_low
    logic [2:0]     class_code;    // detected_charger_class
    logic           det_run;       // start pulse to detector
    logic [2:0]     host_pwr;      // host power request, bit0 = port 1
    logic [2:0]     oc_ind;        // overcurrent_indication
    logic [2:0]     chg_en;        // downstream_charge_enable
    logic [2:0]     pwr_status;    // port_power_on_status

    modport bank (output wr_trigger, wr_found_high, ext_sel, det_disable, det_done,
                  det_kind, type_mask, host_pwr, oc_ind, chg_en,
                  input trigger, done_flag, found_low, class_code, det_run, pwr_status);
    modport det  (input wr_trigger, wr_found_high, ext_sel, det_disable, det_done,
                  det_kind, type_mask,
                  output trigger, done_flag, found_low, class_code, det_run);
    modport pwr  (input host_pwr, oc_ind, chg_en, output pwr_status);
endinterface

// *** rtl/cdp_detect_seq.sv ***
// charger detection sequencer: trigger, completion flag, class and found bit
`timescale 1ns/1ps
module cdp_detect_seq
    import cdp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    cdp_ctl_if.det   ctl
);
    // ==========================================================
    // state
    typedef struct packed {
        cdp_seq_state_t st;     // idle or manual sequence running
        logic           trig;   // trigger bit
        logic           done;   // completion flag
        logic [2:0]     cls;    // class code
        logic           fnd_n;  // found bit, active low
        logic           run;    // start pulse
    } cdp_seq_t;

    cdp_seq_t r_reg;
    cdp_seq_t r_next;
    logic     start;            // manual start accepted
    logic [2:0] code;           // class for this result
    logic     hit;              // unmasked charger found

    // result encoding depends on extended selection
    always_comb begin
        case (ctl.det_kind)
            KIND_DCP: code = CLS_DCP;
            KIND_CDP: code = ctl.ext_sel ? CLS_CDP : CLS_DCP;
            KIND_SDP: code = CLS_SDP;
            default:  code = CLS_INCOMPLETE;
        endcase
        if (ctl.det_disable) begin
            code = CLS_DISABLED;
        end
        hit = (ctl.det_kind != KIND_NONE) && !ctl.det_disable
              && !ctl.type_mask[ctl.det_kind];
    end

    // next state
    always_comb begin
        r_next     = r_reg;
        r_next.run = 1'b0;
        start      = (r_reg.st == SEQ_IDLE) && ctl.wr_trigger;
        case (r_reg.st)
            SEQ_IDLE: begin
                if (start) begin
                    r_next.st   = SEQ_MANUAL;
                    r_next.trig = 1'b1;
                    r_next.done = 1'b0;
                    r_next.run  = 1'b1;
                end
            end
            SEQ_MANUAL: begin
                r_next.st = SEQ_MANUAL;
            end
            default: begin
                r_next.st = SEQ_IDLE;
            end
        endcase
        if (ctl.det_done && !start) begin
            // all results land in one cycle
            r_next.cls   = code;
            r_next.fnd_n = !hit;
            r_next.done  = 1'b1;
            r_next.trig  = 1'b0;
            r_next.st    = SEQ_IDLE;
        end else if (ctl.wr_found_high) begin
            r_next.fnd_n = 1'b1;
        end
    end

    // registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            r_reg <= '{SEQ_IDLE, 1'b0, 1'b0, CLS_INCOMPLETE, 1'b1, 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign ctl.trigger    = r_reg.trig;
    assign ctl.done_flag  = r_reg.done;
    assign ctl.class_code = r_reg.cls;
    assign ctl.found_low  = r_reg.fnd_n;
    assign ctl.det_run    = r_reg.run;
endmodule // cdp_detect_seq

// *** rtl/cdp_port_power.sv ***
// per-port power status from host request, overcurrent and charging enable
`timescale 1ns/1ps
module cdp_port_power
    import cdp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    cdp_ctl_if.pwr   ctl
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [NPORT-1:0] trip;  // overcurrent hit, held until host drops power
        logic [NPORT-1:0] oc_q;  // previous overcurrent level
        logic [NPORT-1:0] sts;   // status bits
    } cdp_pwr_t;

    cdp_pwr_t         r_reg;
    cdp_pwr_t         r_next;
    logic [NPORT-1:0] trip_n;    // next trip per port
    logic [NPORT-1:0] sts_n;     // next status per port

    // per-port decision
    for (genvar i = 0; i < NPORT; i++) begin : g_port
        // a fresh overcurrent clears the bit
        assign trip_n[i] = (ctl.oc_ind[i] & ~r_reg.oc_q[i]) | (r_reg.trip[i] & ctl.host_pwr[i]);
        // charging logic only counts when enabled
        assign sts_n[i]  = ctl.host_pwr[i] & ~(ctl.chg_en[i] & ctl.oc_ind[i]) & ~trip_n[i];
    end

    // next state
    always_comb begin
        r_next       = r_reg;
        r_next.trip  = trip_n;
        r_next.oc_q  = ctl.oc_ind;
        r_next.sts   = sts_n;
    end

    // registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign ctl.pwr_status = r_reg.sts;
endmodule // cdp_port_power

// *** rtl/cdp_regs.sv ***
// charger detection and port power status register bank with apb slave
//
// Functional notes
// - extended mode class codes in bits 7:5
// - legacy mode merges dcp and cdp as 001
// - done flag sets when detection finishes
// - done flag clears when trigger goes high
// - found bit low when unmasked charger found
// - write one forces found bit high, except in a cycle where a detection result lands
// - write one starts manual detection, reads one
// - trigger bit self-clears at sequence end
// - bits 3:1 show per-port power enable
// - zero if unpowered or charging overcurrent
// - status only reflects, writes never control power
// - overcurrent set clears port status bit
// - charging logic active only when enabled
`timescale 1ns/1ps
module cdp_regs
    import cdp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             det_run,
    input  wire logic        det_done,
    input  wire logic [1:0]  det_kind,
    input  wire logic        extended_detection_select,
    input  wire logic        detection_disable,
    input  wire logic [2:0]  charger_type_mask,
    input  wire logic [2:0]  host_port_power,
    input  wire logic [2:0]  overcurrent_indication,
    input  wire logic [2:0]  downstream_charge_enable,
    output logic      [2:0]  port_power_on_status
);
    // ==========================================================
    // helpers and state
    cdp_ctl_if ctl ();

    typedef struct packed {
        logic [31:0]      rdata;  // read data
        logic             err;    // unmapped address
        logic [IRQ_W-1:0] sts;    // sticky events
        logic [IRQ_W-1:0] mask;   // interrupt enables
        logic             irq;    // interrupt line
        logic             done_q; // previous done flag
        logic             fnd_q;  // previous found bit
        logic [2:0]       pwr_q;  // previous port status
    } cdp_bank_t;

    cdp_bank_t        r_reg;
    cdp_bank_t        r_next;
    logic [7:0]       idx;        // register index
    logic             hit;        // address maps to a register
    logic             setup;      // apb setup phase
    logic             acc_wr;     // apb write access
    logic             wr_ucd;     // write to charger detection register
    logic [7:0]       ucd_rd;     // charger detection read view
    logic [IRQ_W-1:0] ev;         // events this cycle
    logic [IRQ_W-1:0] clr;        // software clears

    // ==========================================================
    // sub-blocks
    cdp_detect_seq u_seq (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .ctl     (ctl)
    );

    cdp_port_power u_pwr (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .ctl     (ctl)
    );

    // ==========================================================
    // apb decode; index lives in byte address bits 9:2
    always_comb begin
        idx    = paddr[9:2];
        hit    = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
                 && (idx == IDX_UCD || idx == IDX_PPS
                     || idx == IDX_IRQ_STS || idx == IDX_IRQ_MASK);
        setup  = psel && !penable;
        acc_wr = psel && penable && pwrite && !r_reg.err && pstrb[0];
        wr_ucd = acc_wr && (idx == IDX_UCD);
    end

    // software strobes into the sequencer; writes of zero do nothing
    assign ctl.wr_trigger    = wr_ucd && pwdata[UCD_TRG_BIT];
    assign ctl.wr_found_high = wr_ucd && pwdata[UCD_FND_BIT];

    // pass-through of detector and port inputs
    assign ctl.ext_sel     = extended_detection_select;
    assign ctl.det_disable = detection_disable;
    assign ctl.det_done    = det_done;
    assign ctl.det_kind    = cdp_kind_t'(det_kind);
    assign ctl.type_mask   = charger_type_mask;
    assign ctl.host_pwr    = host_port_power;
    assign ctl.oc_ind      = overcurrent_indication;
    assign ctl.chg_en      = downstream_charge_enable;

    // charger detection read view; reserved 3:2 zero
    always_comb begin
        ucd_rd                         = 8'h00;
        ucd_rd[7:UCD_CLS_LSB]          = ctl.det_disable ? CLS_DISABLED
                                                         : ctl.class_code;
        ucd_rd[UCD_DONE_BIT]           = ctl.done_flag;
        ucd_rd[UCD_FND_BIT]            = ctl.found_low;
        ucd_rd[UCD_TRG_BIT]            = ctl.trigger;
    end

    // ==========================================================
    // events and write-one-to-clear
    always_comb begin
        ev            = '0;
        ev[IRQ_DONE]  = ctl.done_flag & ~r_reg.done_q;
        ev[IRQ_FOUND] = r_reg.fnd_q & ~ctl.found_low;
        ev[IRQ_PWR]   = |(ctl.pwr_status ^ r_reg.pwr_q);
        clr           = '0;
        if (acc_wr && idx == IDX_IRQ_STS) begin
            clr = pwdata[IRQ_W-1:0];
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        r_next        = r_reg;
        r_next.done_q = ctl.done_flag;
        r_next.fnd_q  = ctl.found_low;
        r_next.pwr_q  = ctl.pwr_status;
        // read data and error are prepared in the setup cycle
        if (setup) begin
            r_next.err   = !hit;
            r_next.rdata = 32'h0000_0000;
            if (!pwrite) begin
                case (idx)
                    IDX_UCD:      r_next.rdata[7:0] = ucd_rd;
                    // read only; writes here are dropped
                    IDX_PPS:      r_next.rdata[3:PPS_LSB] = ctl.pwr_status;
                    IDX_IRQ_STS:  r_next.rdata[IRQ_W-1:0] = r_reg.sts;
                    IDX_IRQ_MASK: r_next.rdata[IRQ_W-1:0] = r_reg.mask;
                    default:      r_next.rdata = 32'h0000_0000;
                endcase
            end
        end
        // mask write
        if (acc_wr && idx == IDX_IRQ_MASK) begin
            r_next.mask = pwdata[IRQ_W-1:0];
        end
        // a new event beats a clear in the same cycle
        r_next.sts = (r_reg.sts & ~clr) | ev;
        r_next.irq = |(r_next.sts & r_next.mask);
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            r_reg <= '{32'h0000_0000, 1'b0, '0, '0, 1'b0, 1'b0, 1'b1, 3'h0};
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // outputs
    assign prdata               = r_reg.rdata;
    assign pready               = 1'b1;
    assign pslverr              = psel && penable && r_reg.err;
    assign irq                  = r_reg.irq;
    assign det_run              = ctl.det_run;
    assign port_power_on_status = ctl.pwr_status;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    logic start_ok;  // manual start accepted this cycle
    logic fin;       // a sequence completes this cycle
    assign start_ok = ctl.wr_trigger && !ctl.trigger;
    assign fin      = det_done && !start_ok;

    sequence s_start;
        start_ok;
    endsequence

    sequence s_running;
        ctl.trigger && ctl.det_run ##1 ctl.trigger && !ctl.det_run;
    endsequence

    property p_trig_start;
        s_start |=> s_running;
    endproperty
    a_trig_start: assert property (p_trig_start)
        else $error("manual start not running");

    property p_done_clear;
        s_start |=> !ctl.done_flag && !ucd_rd[UCD_DONE_BIT];
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("done flag not cleared at start");

    property p_done_set;
        fin |=> ctl.done_flag;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("done flag not set at finish");

    property p_trig_self_clear;
        ctl.trigger && det_done |=> !ctl.trigger ##1 (!ctl.trigger || $past(start_ok));
    endproperty
    a_trig_self_clear: assert property (p_trig_self_clear)
        else $error("trigger not cleared at finish");

    property p_class_ext;
        fin && extended_detection_select && !detection_disable
            && det_kind == 2'h1 |=> ctl.class_code == CLS_CDP;
    endproperty
    a_class_ext: assert property (p_class_ext)
        else $error("extended cdp code wrong");

    property p_class_legacy;
        fin && !extended_detection_select && !detection_disable
            && det_kind == 2'h1 |=> ctl.class_code == CLS_DCP;
    endproperty
    a_class_legacy: assert property (p_class_legacy)
        else $error("legacy cdp code wrong");

    property p_found;
        fin && det_kind == 2'h0 && !detection_disable && !charger_type_mask[0]
            |=> !ctl.found_low && ctl.done_flag && !ctl.trigger;
    endproperty
    a_found: assert property (p_found)
        else $error("found bit or joint update wrong");

    property p_found_force;
        ctl.wr_found_high && !det_done |=> ctl.found_low;
    endproperty
    a_found_force: assert property (p_found_force)
        else $error("found bit not forced high");

    property p_found_zero;
        wr_ucd && !pwdata[UCD_FND_BIT] && !det_done |=> $stable(ctl.found_low);
    endproperty
    a_found_zero: assert property (p_found_zero)
        else $error("write of zero changed found bit");

    property p_pwr_off;
        !host_port_power[0] |=> !port_power_on_status[0];
    endproperty
    a_pwr_off: assert property (p_pwr_off)
        else $error("unpowered port shows power");

    property p_oc_clear;
        $rose(overcurrent_indication[1]) |=> !port_power_on_status[1];
    endproperty
    a_oc_clear: assert property (p_oc_clear)
        else $error("overcurrent did not clear status");

    property p_pps_read;
        setup && !pwrite && idx == IDX_PPS
            |=> prdata[3:1] == $past(ctl.pwr_status) && prdata[0] == 1'b0;
    endproperty
    a_pps_read: assert property (p_pps_read)
        else $error("port status read wrong");

    property p_reserved;
        setup && !pwrite && idx == IDX_UCD |=> prdata[3:2] == 2'h0 && prdata[31:8] == '0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits not zero");

    // a zero in the trigger bit must not start anything
    property p_trig_zero;
        wr_ucd && !pwdata[UCD_TRG_BIT] && !ctl.trigger |=> !ctl.trigger;
    endproperty
    a_trig_zero: assert property (p_trig_zero)
        else $error("write of zero started detection");

    property p_trig_hold;
        ctl.trigger && !det_done |=> ctl.trigger;
    endproperty
    a_trig_hold: assert property (p_trig_hold)
        else $error("trigger dropped while running");

    property p_pwr_on;
        $rose(host_port_power[0]) && !overcurrent_indication[0]
            && !$past(overcurrent_indication[0]) |=> port_power_on_status[0];
    endproperty
    a_pwr_on: assert property (p_pwr_on)
        else $error("powered port without overcurrent shows off");

    property p_charge_oc;
        host_port_power[1] && downstream_charge_enable[1] && overcurrent_indication[1]
            |=> !port_power_on_status[1];
    endproperty
    a_charge_oc: assert property (p_charge_oc)
        else $error("charging overcurrent left port powered");
endmodule // cdp_regs

// *** tb/cdp_det_model.sv ***
// behavioural analog charger detector answering start pulses after a delay
`timescale 1ns/1ps
module cdp_det_model #(
    parameter int DLY = 10  // cycles from start pulse to result
) (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       det_run,
    input  wire logic [1:0] kind_sel,
    output logic            det_done,
    output logic      [1:0] det_kind
);
    // ==========================================
    // sequence timer
    int cnt;  // cycles left in the running sequence
    // result stands one cycle; kind toggles outside it so stale values never pass
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt      <= 0;
            det_done <= 1'b0;
            det_kind <= 2'b00;
        end else begin
            det_done <= (cnt == 1);
            det_kind <= (cnt == 1) ? kind_sel : ~det_kind;
            if (det_run) begin
                cnt <= DLY;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule // cdp_det_model

// *** tb/tb.sv ***
// self-checking bench for the charger detection and port power register bank
`timescale 1ns/1ps
module tb;
    import cdp_pkg::*;
    // ==========================================
    // signals
    logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
    logic        det_run, det_done, ext_sel, det_dis, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [1:0]  det_kind, kind_sel;
    logic [2:0]  cmask, host, oc_in, chg_en, pps;
    int          err_count, num_checks;

    cdp_regs cdp_regs_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .det_run(det_run),
        .det_done(det_done), .det_kind(det_kind), .extended_detection_select(ext_sel),
        .detection_disable(det_dis), .charger_type_mask(cmask), .host_port_power(host),
        .overcurrent_indication(oc_in), .downstream_charge_enable(chg_en),
        .port_power_on_status(pps));
    cdp_det_model cdp_det_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .det_run(det_run), .kind_sel(kind_sel), .det_done(det_done), .det_kind(det_kind));

    // ==========================================
    // clock and checking helpers
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one apb transfer: setup, then access until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, idx, d, r);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, idx, 32'h0000_0000, r);
        chk(r, e);
    endtask

    // ==========================================
    // scenarios
    // manual run: trigger reads 1 and done 0 while running, then full result at once
    task automatic t_detect(input logic [1:0] k, input logic x);
        logic [31:0] r;
        logic [2:0]  c;
        kind_sel <= k;
        ext_sel  <= x;
        wr(IDX_UCD, 32'h0000_0001);
        apb(1'b0, IDX_UCD, 32'h0000_0000, r);
        chk(r[UCD_TRG_BIT], 1'b1);
        chk(r[UCD_DONE_BIT], 1'b0);
        while (det_done !== 1'b1) begin
            @(posedge clk_sys);
        end
        c = (k == 2'd0) ? 3'h1 : (k == 2'd1) ? (x ? 3'h2 : 3'h1) : (k == 2'd2) ? 3'h3 : 3'h0;
        rd(IDX_UCD, {24'h0, c, 3'b100, ~(k != 2'd3 && !cmask[k]), 1'b0});
    endtask
    // found bit: one forces it high, zero leaves it and starts nothing
    task automatic t_found();
        wr(IDX_UCD, 32'h0000_0002);
        rd(IDX_UCD, 32'h0000_0032);
        wr(IDX_UCD, 32'h0000_000C);
        rd(IDX_UCD, 32'h0000_0032);
    endtask
    // port status follows host request, overcurrent and charging enable
    task automatic t_power();
        host   <= 3'b111;
        chg_en <= 3'b100;
        repeat (2) @(posedge clk_sys);
        chk(pps, 3'b111);
        wr(IDX_PPS, 32'h0000_00F1);
        rd(IDX_PPS, 32'h0000_000E);
        oc_in <= 3'b010;
        repeat (2) @(posedge clk_sys);
        chk(pps, 3'b101);
        host <= 3'b011;
        repeat (2) @(posedge clk_sys);
        rd(IDX_PPS, 32'h0000_0002);
        // host cycles port 2 with overcurrent standing: only charging blocks it
        host <= 3'b001;
        repeat (2) @(posedge clk_sys);
        host <= 3'b011;
        repeat (2) @(posedge clk_sys);
        chk(pps, 3'b011);
        chg_en <= 3'b110;
        repeat (2) @(posedge clk_sys);
        chk(pps, 3'b001);
    endtask

    // ==========================================
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        end_of_test();
    end
    // main sequence
    initial begin
        err_count = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        {psel, penable, pwrite, ext_sel, det_dis} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        kind_sel = '0;
        {cmask, host, oc_in, chg_en} = '0;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(IDX_UCD, {24'h0, UCD_RST});
        rd(IDX_PPS, {24'h0, PPS_RST});
        wr(IDX_IRQ_MASK, 32'h0000_0001);
        t_detect(2'd0, 1'b1);
        chk(irq, 1'b1);
        wr(IDX_IRQ_STS, 32'h0000_0001);
        @(posedge clk_sys);
        chk(irq, 1'b0);
        t_found();
        cmask <= 3'b100;
        t_detect(2'd1, 1'b1);
        t_detect(2'd2, 1'b1);
        t_detect(2'd3, 1'b1);
        t_detect(2'd1, 1'b0);
        det_dis <= 1'b1;
        rd(IDX_UCD, 32'h0000_00F0);
        det_dis <= 1'b0;
        t_power();
        // a write without the low byte strobe must leave the mask alone
        pstrb <= 4'hE;
        wr(IDX_IRQ_MASK, 32'h0000_0000);
        pstrb <= 4'hF;
        rd(IDX_IRQ_MASK, 32'h0000_0001);
        rd(8'h10, 32'h0000_0000);
        chk(last_err, 1'b1);
        end_of_test();
    end
endmodule // tb
